// >>> rtl/dcc_top.sv
`timescale 1ns/10ps
`include "dcc_consts.svh"

module dcc_top
   import dcc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        first_raw_i,
   input  wire logic        second_raw_i,
   input  wire logic        timer_clk_i,
   input  wire logic        gate_input_pin_i,
   output logic             timer_gate_o,
   output logic             irq_o,
   output logic             wake_o,
   output logic             first_on_o,
   output logic             second_on_o,
   output logic             pins_digital_o,
   output logic             result_pins_drive_o,
   output logic             first_result_pin_o,
   output logic             second_result_pin_o,
   output logic             first_inv_from_pos_o,
   output logic             second_inv_from_pos_o,
   output logic             second_noninv_ref_o,
   output logic             reference_enable_o,
   output logic             reference_range_o,
   output logic [3:0]       reference_level_o,
   output logic [2:0]       comparator_mode_field_o
);

   // ****************************************
   // State and bus decode
   // ****************************************
   dcc_state_s q;
   dcc_state_s next_q;

   logic       addr_ph;
   logic [7:0] addr;
   logic [1:0] mismatch;
   logic [2:0] mode;
   logic [1:0] pol;
   logic       input_switch_select;

   // Address phase taken when selected, nonsequential or sequential and bus ready
   assign addr_ph  = hsel_i & htrans_i[1] & hready_i;
   assign addr     = haddr_i[7:0];
   assign mode     = q.cfg[`DCC_CFG_MODE_LSB +: 3];
   assign pol      = {q.cfg[`DCC_CFG_POL2], q.cfg[`DCC_CFG_POL1]};
   assign input_switch_select      = q.cfg[`DCC_CFG_CIS];
   assign mismatch = q.res ^ q.ref_latch;

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      next_q = q;
      // Three-stage synchronisers; the first stage only feeds the second
      next_q.sy1 = {q.sy1[1:0], first_raw_i};
      next_q.sy2 = {q.sy2[1:0], second_raw_i};
      next_q.syt = {q.syt[1:0], timer_clk_i};
      next_q.syg = {q.syg[1:0], gate_input_pin_i};
      if (q.sy1[1] == q.sy1[2]) next_q.f1 = q.sy1[2];
      if (q.sy2[1] == q.sy2[2]) next_q.f2 = q.sy2[2];
      if (q.syt[1] == q.syt[2]) next_q.ft = q.syt[2];
      if (q.syg[1] == q.syg[2]) next_q.fg = q.syg[2];

      // Results with polarity, tracked every cycle, sleep or not
      next_q.res = {q.f2, q.f1} ^ pol;

      // Latch second result on falling timer clock edge
      if (q.ft && (q.syt[1] == q.syt[2]) && !q.syt[2])
         next_q.c2_held = q.res[1];
      if (!q.link[`DCC_LNK_GSS])
         next_q.gate = q.link[`DCC_LNK_SYNC] ? q.c2_held : q.res[1];
      else
         next_q.gate = q.fg;

      // Flags: hardware set beats a software clear
      next_q.flags = q.flags | mismatch;

      // Bus: read answers after one wait state, write lands in data phase
      next_q.hready  = 1'b1;
      next_q.rd_pend = 1'b0;
      next_q.wr_pend = 1'b0;
      if (q.rd_pend)
      begin
         next_q.hrdata = 32'h0;
         unique case (q.rd_addr)
            `DCC_OFF_CONFIG:  next_q.hrdata[7:0] = {q.res, q.cfg};
            `DCC_OFF_LINK:    next_q.hrdata[1:0] = q.link;
            `DCC_OFF_REF:     next_q.hrdata[7:0] = q.vref;
            `DCC_OFF_FLAGS:   next_q.hrdata[1:0] = q.flags;
            `DCC_OFF_ENABLES: next_q.hrdata[7:0] = q.irq_en;
            default:          next_q.hrdata = 32'h0;
         endcase
      end
      if (q.wr_pend)
      begin
         unique case (q.wr_addr)
            `DCC_OFF_CONFIG:  next_q.cfg = hwdata_i[5:0];
            `DCC_OFF_LINK:    next_q.link = hwdata_i[1:0];
            `DCC_OFF_REF:     next_q.vref = hwdata_i[7:0] & `DCC_MASK_REF;
            `DCC_OFF_FLAGS:   next_q.flags = hwdata_i[1:0] | mismatch;
            `DCC_OFF_ENABLES: next_q.irq_en = hwdata_i[7:0] & 8'hc3;
            default:          next_q.irq_en = q.irq_en;
         endcase
      end
      if (addr_ph)
      begin
         next_q.wr_pend = hwrite_i;
         next_q.wr_addr = addr;
         next_q.rd_pend = ~hwrite_i;
         next_q.rd_addr = addr;
         next_q.hready  = hwrite_i;
         // Any access to config (writes read first) reloads the latch
         if (addr == `DCC_OFF_CONFIG)
            next_q.ref_latch = q.res;
      end

      // Interrupt and wake requests
      next_q.wake = |(q.flags & q.irq_en[1:0]) & q.irq_en[`DCC_EN_PERIPH];
      next_q.irq  = next_q.wake & q.irq_en[`DCC_EN_GLOBAL];

      // Analog-side controls decoded from mode and switch bit; result pins copied from results
      next_q.pins[0] = (mode != `DCC_MODE_OFF_AN) && (mode != `DCC_MODE_OFF_DIG)
                       && (mode != `DCC_MODE_ONE);
      next_q.pins[1] = (mode != `DCC_MODE_OFF_AN) && (mode != `DCC_MODE_OFF_DIG);
      next_q.pins[2] = (mode == `DCC_MODE_OFF_DIG);
      next_q.pins[3] = (mode == `DCC_MODE_OUTPIN);
      next_q.pins[4] = input_switch_select && ((mode == `DCC_MODE_FOUR) || (mode == `DCC_MODE_THREE));
      next_q.pins[5] = input_switch_select && (mode == `DCC_MODE_FOUR);
      next_q.pins[6] = input_switch_select && (mode == `DCC_MODE_ONE);
      next_q.pins[8:7] = q.res;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         q        <= '0;
         q.cfg    <= `DCC_RST_CONFIG;
         q.link   <= `DCC_RST_LINK;
         q.vref   <= `DCC_RST_REF;
         q.hready <= 1'b1;
      end
      else
      begin
         q <= next_q;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign hrdata_o              = q.hrdata;
   assign hreadyout_o           = q.hready;
   assign hresp_o               = q.wr_pend & 1'b0;
   assign timer_gate_o          = q.gate;
   assign irq_o                 = q.irq;
   assign wake_o                = q.wake;
   assign first_on_o            = q.pins[0];
   assign second_on_o           = q.pins[1];
   assign pins_digital_o        = q.pins[2];
   assign result_pins_drive_o   = q.pins[3];
   assign first_inv_from_pos_o  = q.pins[4];
   assign second_inv_from_pos_o = q.pins[5];
   assign second_noninv_ref_o   = q.pins[6];
   assign first_result_pin_o    = q.pins[7];
   assign second_result_pin_o   = q.pins[8];
   // Disabled reference powers down and clamps to ground
   assign reference_enable_o    = q.vref[`DCC_REF_EN];
   assign reference_range_o     = q.vref[`DCC_REF_RANGE];
   assign reference_level_o     = q.vref[3:0];
   assign comparator_mode_field_o = mode;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   flag_sets_a: assert property (mismatch[0] |=> q.flags[0])
      else $error("first change flag not set on mismatch");
   clear_blocked_a: assert property (q.wr_pend && q.wr_addr == `DCC_OFF_FLAGS
         && mismatch[1] |=> q.flags[1])
      else $error("flag cleared while mismatch persists");
   latch_reload_a: assert property (addr_ph && addr == `DCC_OFF_CONFIG
         |=> q.ref_latch == $past(q.res))
      else $error("reference latch not reloaded on config access");
   ro_results_a: assert property (q.wr_pend && q.wr_addr == `DCC_OFF_CONFIG
         |=> q.cfg == $past(hwdata_i[5:0]))
      else $error("config write stored wrong bits");
   link_zero_a: assert property (q.rd_pend && q.rd_addr == `DCC_OFF_LINK
         |=> q.hrdata[31:2] == 30'h0 && q.hrdata[1:0] == $past(q.link))
      else $error("link readback wrong");
   irq_gate_a: assert property (q.irq |-> $past(q.irq_en[`DCC_EN_GLOBAL])
         && $past(q.irq_en[`DCC_EN_PERIPH]))
      else $error("request without all enables");
   wake_a: assert property ((|(q.flags & q.irq_en[1:0])) && q.irq_en[`DCC_EN_PERIPH]
         |=> q.wake)
      else $error("wake missing");
   gate_sel_a: assert property (q.link[`DCC_LNK_GSS] |=> q.gate == $past(q.fg))
      else $error("gate not from pin");
   off_mode_a: assert property ((mode == `DCC_MODE_OFF_AN || mode == `DCC_MODE_OFF_DIG)
         |=> !q.pins[0] && !q.pins[1])
      else $error("comparator on in off mode");
   read_wait_a: assert property (addr_ph && !hwrite_i |=> !q.hready ##1 q.hready)
      else $error("read timing wrong");

   flag_cov_c: cover property (mismatch[0] ##1 q.flags[0]);
   irq_cov_c: cover property (!q.irq ##1 q.irq);
   held_cov_c: cover property (q.link == 2'h1 ##1 q.c2_held != $past(q.c2_held));

endmodule : dcc_top

// >>> rtl/dcc_consts.svh
// What this block does
// - Mode 000 turns both comparators off with analog pins; 111 off, pins digital.
// - Mode codes 001 to 110 pick the six comparator input arrangements.
// - Result bit is 1 when plus input exceeds minus input, inverted by polarity.
// - Both result bits in the configuration register are read-only.
// - Switch bit routes positive pin to inverting input: mode 010 both, 001 first.
// - In mode 101 switch bit ties second non-inverting input to fixed reference.
// - Reset returns both comparator registers to reset values, mode 000.
// - An enabled comparator keeps tracking and detecting changes during sleep.
// - Change wakes device when its enable and peripheral enable are set.
// - After wake, next instruction runs first; service routine only with global enable.
// - A change coinciding with a configuration read may miss its flag.
// - Gate select clear picks second comparator as timer gate; set picks pin.
// - With sync set, second result latches on falling timer clock edge.
// - Timer counts on rising edge while gate is captured on falling edge.
// - Timer-link bits 7 to 2 read zero and ignore writes.
// - Reference enable powers reference; clear powers down and outputs ground.
// - Range bit 1 selects low range; 4-bit level picks one of 16 taps.
// - Disabled, low range, level zero: output clamped to ground, no current.
// - Change flag sets whenever result differs from latch of last configuration access.
// - Any configuration read or write, and reset, reloads the reference latch.
// - Flag clears only by writing 0, writing 1 sets it; mismatch blocks clear.
// - Interrupt request needs own, peripheral and global enables; flag sets anyway.
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DCC_OFF_CONFIG   8'h00
`define DCC_OFF_LINK     8'h04
`define DCC_OFF_REF      8'h08
`define DCC_OFF_FLAGS    8'h0c
`define DCC_OFF_ENABLES  8'h10

// ****************************************
// Reset values and writable masks
// ****************************************
`define DCC_RST_CONFIG   6'h00
`define DCC_RST_LINK     2'h2
`define DCC_RST_REF      8'h00
`define DCC_MASK_REF     8'haf

// ****************************************
// Field positions
// ****************************************
`define DCC_CFG_MODE_LSB 0
`define DCC_CFG_CIS      3
`define DCC_CFG_POL1     4
`define DCC_CFG_POL2     5
`define DCC_LNK_SYNC     0
`define DCC_LNK_GSS      1
`define DCC_REF_EN       7
`define DCC_REF_RANGE    5
`define DCC_EN_PERIPH    6
`define DCC_EN_GLOBAL    7

// ****************************************
// Mode codes
// ****************************************
`define DCC_MODE_OFF_AN  3'h0
`define DCC_MODE_THREE   3'h1
`define DCC_MODE_FOUR    3'h2
`define DCC_MODE_COMREF  3'h3
`define DCC_MODE_INDEP2  3'h4
`define DCC_MODE_ONE     3'h5
`define DCC_MODE_OUTPIN  3'h6
`define DCC_MODE_OFF_DIG 3'h7

`endif

// >>> rtl/dcc_pkg.sv
package dcc_pkg;

   // All state of the control block
   typedef struct packed {
      logic [5:0]  cfg;
      logic [1:0]  res;
      logic [1:0]  ref_latch;
      logic [1:0]  flags;
      logic [1:0]  link;
      logic [7:0]  vref;
      logic [7:0]  irq_en;
      logic [2:0]  sy1;
      logic [2:0]  sy2;
      logic [2:0]  syt;
      logic [2:0]  syg;
      logic        f1;
      logic        f2;
      logic        ft;
      logic        fg;
      logic        c2_held;
      logic        gate;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic        rd_pend;
      logic [7:0]  rd_addr;
      logic [31:0] hrdata;
      logic        hready;
      logic        irq;
      logic        wake;
      logic [8:0]  pins;
   } dcc_state_s;

endpackage : dcc_pkg

// >>> verification/dcc_timer_model.sv
`timescale 1ns/10ps

module dcc_timer_model
(
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        gate_i,
   output logic             timer_clk_o,
   output logic [15:0]      count_o
);
   logic [2:0] div;

   // Timer clock after prescaler, sixteen system cycles a period
   always_ff @(posedge clk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         div         <= 3'h0;
         timer_clk_o <= 1'b0;
      end
      else
      begin
         div <= div + 3'h1;
         if (div == 3'h7)
            timer_clk_o <= ~timer_clk_o;
      end

   // Counts on the rising timer edge while the gate is open
   always_ff @(posedge timer_clk_o or negedge nrst_i)
      if (!nrst_i)
         count_o <= 16'h0;
      else if (gate_i)
         count_o <= count_o + 16'h1;
endmodule : dcc_timer_model

// >>> verification/dcc_top_test.sv
`timescale 1ns/10ps
`include "dcc_consts.svh"

module dcc_top_test;
   logic clk_i, nrst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, d, v;
   logic [1:0]  htrans_i;
   logic first_raw_i, second_raw_i, timer_clk_i, gate_input_pin_i, timer_gate_o;
   logic irq_o, wake_o, first_on_o, second_on_o, pins_digital_o, result_pins_drive_o;
   logic first_result_pin_o, second_result_pin_o, first_inv_from_pos_o;
   logic second_inv_from_pos_o, second_noninv_ref_o, reference_enable_o, reference_range_o;
   logic [3:0]  reference_level_o;
   logic [2:0]  comparator_mode_field_o;
   logic [15:0] count, c0;
   int          errors, compares, cycles, seed, i;

   assign hready_i = hreadyout_o;

   dcc_top u_dut (.clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i(3'h2), .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
      .first_raw_i, .second_raw_i, .timer_clk_i, .gate_input_pin_i, .timer_gate_o,
      .irq_o, .wake_o, .first_on_o, .second_on_o, .pins_digital_o, .result_pins_drive_o,
      .first_result_pin_o, .second_result_pin_o, .first_inv_from_pos_o,
      .second_inv_from_pos_o, .second_noninv_ref_o, .reference_enable_o,
      .reference_range_o, .reference_level_o, .comparator_mode_field_o);

   dcc_timer_model u_timer (.clk_i, .nrst_i, .gate_i(timer_gate_o),
      .timer_clk_o(timer_clk_i), .count_o(count));

   // ****************************************
   // Clock, timeout and checking
   // ****************************************
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // Cuts a hang short
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         finish_test();
      end
   end

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic finish_test;
      if (errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   // One single AHB-Lite transfer, address phase held until ready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      hsel_i   <= 1'b1;
      htrans_i <= 2'b10;
      haddr_i  <= {24'h0, a};
      hwrite_i <= w;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
      htrans_i <= 2'b00;
      hwdata_i <= wd;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
      d = hrdata_o;
   endtask : bus

   // Expected routing outputs for a mode and switch setting
   function automatic logic [6:0] route(input logic [2:0] m, input logic s);
      return {m inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6}, m inside {[3'h1:3'h6]},
              m == 3'h7, m == 3'h6, s & (m == 3'h1 || m == 3'h2), s & (m == 3'h2),
              s & (m == 3'h5)};
   endfunction : route

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      seed = 32'h189d;
      {nrst_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
      {first_raw_i, second_raw_i, gate_input_pin_i} = '0;
      repeat (16) @(posedge clk_i);
      nrst_i <= 1'b1;
      bus(0, `DCC_OFF_CONFIG, 0); chk("config", d, 32'h0);
      bus(0, `DCC_OFF_LINK, 0); chk("link", d, 32'h2);
      bus(0, `DCC_OFF_REF, 0); chk("ref", d, 32'h0);
      // Random register contents and comparator inputs
      for (i = 0; i < 8; i++)
      begin
         v = $random(seed);
         bus(1, `DCC_OFF_REF, v); bus(0, `DCC_OFF_REF, 0);
         chk("ref", d, v & 32'haf);
         chk("refpins", {reference_enable_o, reference_range_o, reference_level_o},
             {v[7], v[5], v[3:0]});
         bus(1, `DCC_OFF_LINK, v); bus(0, `DCC_OFF_LINK, 0); chk("link", d, v & 32'h3);
         first_raw_i  <= v[8];
         second_raw_i <= v[9];
         repeat (10) @(posedge clk_i);
         bus(1, `DCC_OFF_CONFIG, v); bus(0, `DCC_OFF_CONFIG, 0);
         chk("config", d, {v[9] ^ v[5], v[8] ^ v[4], v[5:0]});
         chk("respins", {second_result_pin_o, first_result_pin_o}, {v[9]^v[5], v[8]^v[4]});
      end
      // Every mode with the switch both ways
      for (i = 0; i < 16; i++)
      begin
         bus(1, `DCC_OFF_CONFIG, i);
         repeat (2) @(posedge clk_i);
         chk("mode", comparator_mode_field_o, i & 7);
         chk("route", {first_on_o, second_on_o, pins_digital_o, result_pins_drive_o,
             first_inv_from_pos_o, second_inv_from_pos_o, second_noninv_ref_o},
             route(i[2:0], i[3]));
      end
      // Change flag, interrupt and wake
      // Settle, end the mismatch and clear flags before enabling requests
      bus(1, `DCC_OFF_CONFIG, 32'h04);
      repeat (10) @(posedge clk_i);
      bus(0, `DCC_OFF_CONFIG, 0); bus(1, `DCC_OFF_FLAGS, 0);
      bus(0, `DCC_OFF_FLAGS, 0); chk("flags", d, 32'h0);
      bus(1, `DCC_OFF_ENABLES, 32'hc3);
      repeat (2) @(posedge clk_i);
      chk("irq", irq_o, 0);
      first_raw_i <= ~first_raw_i;
      repeat (10) @(posedge clk_i);
      bus(0, `DCC_OFF_FLAGS, 0); chk("flags", d, 32'h1);
      chk("irq", irq_o, 1);
      chk("wake", wake_o, 1);
      bus(1, `DCC_OFF_FLAGS, 0); bus(0, `DCC_OFF_FLAGS, 0); chk("flags", d, 32'h1);
      bus(0, `DCC_OFF_CONFIG, 0); bus(1, `DCC_OFF_FLAGS, 0);
      bus(0, `DCC_OFF_FLAGS, 0); chk("flags", d, 32'h0);
      repeat (2) @(posedge clk_i);
      chk("irq", irq_o, 0);
      bus(1, `DCC_OFF_FLAGS, 2); bus(0, `DCC_OFF_FLAGS, 0); chk("flags", d, 32'h2);
      bus(1, `DCC_OFF_ENABLES, 32'h43);
      repeat (2) @(posedge clk_i);
      chk("irq", irq_o, 0);
      chk("wake", wake_o, 1);
      bus(1, `DCC_OFF_FLAGS, 0); bus(1, `DCC_OFF_ENABLES, 0);
      // Timer gate source and synchronisation
      bus(1, `DCC_OFF_LINK, 0); second_raw_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk("gate", timer_gate_o, 1);
      second_raw_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk("gate", timer_gate_o, 0);
      bus(1, `DCC_OFF_LINK, 2); gate_input_pin_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk("gate", timer_gate_o, 1);
      c0 = count;
      repeat (64) @(posedge clk_i);
      chk("count", count, c0 + 16'h4);
      bus(1, `DCC_OFF_LINK, 1);
      @(negedge timer_clk_i);
      repeat (6) @(posedge clk_i);
      second_raw_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("gate", timer_gate_o, 0);
      repeat (16) @(posedge clk_i);
      chk("gate", timer_gate_o, 1);
      finish_test();
   end
endmodule : dcc_top_test
